// ==== hw/irt_params.svh ====
// Offsets, field positions, reset values and timing counts of the IR timer
`ifndef IRT_PARAMS_SVH
`define IRT_PARAMS_SVH

// Register offsets from the port base (bank 2)
`define IRT_OFS_START 3'h4
`define IRT_OFS_IRQ 3'h5
`define IRT_BANK_IR 2'h2

// Field positions of the enable/status register
`define IRT_BIT_CD_EN 7
`define IRT_BIT_CD_FLAG 6
`define IRT_BIT_TMR_EN 1
`define IRT_BIT_TMR_FLAG 0

// Reset values
`define IRT_RST_START 8'h00
`define IRT_RST_EN 1'b0

// Tick period in ns and clock period in ns
`define IRT_TICK_NS 128000
`define IRT_CLK_NS 10
`define IRT_TICK_CYC (`IRT_TICK_NS / `IRT_CLK_NS)

`endif

// ==== hw/irt_pkg.sv ====
// Types shared by the IR timer block
`default_nettype none
package irt_pkg;
    typedef logic [7:0] irt_byte_t;
endpackage
`default_nettype wire

// ==== hw/irt_timer.sv ====
// Interval timer and carrier/timer interrupt status of the IR controller
`timescale 1ns/1ps
`default_nettype none
`include "irt_params.svh"

// Contract
// - Software writes an 8-bit start value for the interval down counter.
// - The down counter steps once every 128 us, so the interval is start times 128 us.
// - On reaching zero the counter sets the timer pending flag.
// - Bit 7 enables carrier-detect interrupts; when clear, carrier detect raises none.
// - Bit 6 is set when a 500 kHz keyed carrier is detected.
// - Writing one to bit 6 clears the carrier flag; writing zero leaves it.
// - Bit 1 enables the timer interrupt; when clear the pending flag drives nothing.
// - Bit 0 reads one while a timer interrupt is pending; writing one clears it.
// - The pending flag needs no write of zero to rearm.
module irt_timer
    import irt_pkg::*;
#(
    parameter int TICK_CYCLES = `IRT_TICK_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register port, one-cycle strobes
    input wire logic [2:0] reg_addr,
    input wire logic [1:0] reg_bank,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Carrier detector event, one-cycle pulse
    input wire logic carrier_detect,
    // Interrupt request
    output logic irq
);

    // Ticks must be at least three cycles apart for the spacing check
    if (TICK_CYCLES < 3) begin : g_bad_tick
        $error("TICK_CYCLES must be at least 3");
    end

    localparam int TW = $clog2(TICK_CYCLES);

    irt_byte_t start_value;
    logic cd_en;
    logic cd_flag;
    logic tmr_en;
    logic tmr_flag;
    irt_byte_t count;
    logic [TW-1:0] prescale;
    logic running;
    logic tick;
    logic wr_start;
    logic wr_irq;
    logic rd_hit;
    logic hit_zero;
    irt_byte_t next_rdata;

    // Address decode for bank 2
    assign wr_start = reg_wr && reg_bank == `IRT_BANK_IR
        && reg_addr == `IRT_OFS_START;
    assign wr_irq = reg_wr && reg_bank == `IRT_BANK_IR
        && reg_addr == `IRT_OFS_IRQ;
    assign rd_hit = reg_rd && reg_bank == `IRT_BANK_IR;
    assign tick = prescale == TW'(TICK_CYCLES - 1);
    // A start write in the same cycle wins over an expiring count
    assign hit_zero = running && tick && !wr_start && count == 8'h01;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            start_value <= `IRT_RST_START;
        end else if (wr_start) begin
            start_value <= reg_wdata;
        end
    end

    // Enable bits
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cd_en <= `IRT_RST_EN;
            tmr_en <= `IRT_RST_EN;
        end else if (wr_irq) begin
            cd_en <= reg_wdata[`IRT_BIT_CD_EN];
            tmr_en <= reg_wdata[`IRT_BIT_TMR_EN];
        end
    end

    // tick prescaler, restarted by a start-value write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prescale <= '0;
        end else if (wr_start || tick) begin
            prescale <= '0;
        end else begin
            prescale <= prescale + TW'(1);
        end
    end

    // down counter loaded by a start-value write
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 8'h00;
            running <= 1'b0;
        end else if (wr_start) begin
            count <= reg_wdata;
            running <= reg_wdata != 8'h00;
        end else if (running && tick) begin
            count <= count - 8'h01;
            running <= count != 8'h01;
        end
    end

    // timer pending flag, set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tmr_flag <= 1'b0;
        end else if (hit_zero) begin
            tmr_flag <= 1'b1;
        end else if (wr_irq && reg_wdata[`IRT_BIT_TMR_FLAG]) begin
            tmr_flag <= 1'b0;
        end
    end

    // carrier flag, set wins over clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cd_flag <= 1'b0;
        end else if (carrier_detect) begin
            cd_flag <= 1'b1;
        end else if (wr_irq && reg_wdata[`IRT_BIT_CD_FLAG]) begin
            cd_flag <= 1'b0;
        end
    end

    // Read data mux, reserved bits read zero
    always_comb begin
        next_rdata = 8'h00;
        if (reg_addr == `IRT_OFS_START) begin
            next_rdata = start_value;
        end else if (reg_addr == `IRT_OFS_IRQ) begin
            next_rdata[`IRT_BIT_CD_EN] = cd_en;
            next_rdata[`IRT_BIT_CD_FLAG] = cd_flag;
            next_rdata[`IRT_BIT_TMR_EN] = tmr_en;
            next_rdata[`IRT_BIT_TMR_FLAG] = tmr_flag;
        end
    end

    // Registered read data, held until the next bank-2 read
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (rd_hit) begin
            reg_rdata <= next_rdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            irq <= 1'b0;
        end else begin
            irq <= (tmr_flag && tmr_en) || (cd_flag && cd_en);
        end
    end

    chk_timer_sets_flag:
    assert property (@(posedge clk) disable iff (!rst_b)
        hit_zero |=> tmr_flag)
    else $error("timer expiry did not set pending flag");

    chk_tick_spacing:
    assert property (@(posedge clk) disable iff (!rst_b)
        tick && !wr_start |=> !tick [*2])
    else $error("ticks closer than the period");

    chk_count_steps:
    assert property (@(posedge clk) disable iff (!rst_b)
        running && tick && !wr_start |=> count == $past(count) - 8'h01)
    else $error("counter did not step on tick");

    chk_cd_sets:
    assert property (@(posedge clk) disable iff (!rst_b)
        carrier_detect |=> cd_flag)
    else $error("carrier detect not flagged");

    chk_cd_clear:
    assert property (@(posedge clk) disable iff (!rst_b)
        wr_irq && reg_wdata[6] && !carrier_detect |=> !cd_flag)
    else $error("carrier flag not cleared by write one");

    chk_cd_hold:
    assert property (@(posedge clk) disable iff (!rst_b)
        wr_irq && !reg_wdata[6] && cd_flag |=> cd_flag)
    else $error("carrier flag lost on write zero");

    chk_tmr_clear:
    assert property (@(posedge clk) disable iff (!rst_b)
        wr_irq && reg_wdata[0] && !hit_zero |=> !tmr_flag)
    else $error("pending flag not cleared by write one");

    chk_irq_masked:
    assert property (@(posedge clk) disable iff (!rst_b)
        !(tmr_flag && tmr_en) && !(cd_flag && cd_en) |=> !irq)
    else $error("interrupt raised with no enabled flag");

    chk_irq_raised:
    assert property (@(posedge clk) disable iff (!rst_b)
        tmr_flag && tmr_en |=> irq)
    else $error("enabled timer flag raised no interrupt");

    chk_cd_irq:
    assert property (@(posedge clk) disable iff (!rst_b)
        cd_flag && cd_en |=> irq)
    else $error("enabled carrier flag raised no interrupt");

    // Start value store: only a bank-2 write at the start offset lands.
    // A write anywhere else must leave the stored value untouched.

    chk_start_store:
    assert property (@(posedge clk) disable iff (!rst_b)
        wr_start |=> start_value == $past(reg_wdata))
    else $error("start value not stored");

    chk_start_other:
    assert property (@(posedge clk) disable iff (!rst_b)
        reg_wr && !wr_start |=> start_value == $past(start_value))
    else $error("start value changed by a foreign write");

    // Down counter: load, prescaler step, idle hold and stop at zero.
    // The counter is one-shot, so once stopped it must stay parked
    // until software loads a new start value.

    chk_load_count:
    assert property (@(posedge clk) disable iff (!rst_b)
        wr_start |=> count == $past(reg_wdata))
    else $error("counter not loaded by start write");

    chk_prescale_step:
    assert property (@(posedge clk) disable iff (!rst_b)
        !wr_start && !tick |=> prescale == $past(prescale) + TW'(1))
    else $error("prescaler did not advance");

    chk_idle_hold:
    assert property (@(posedge clk) disable iff (!rst_b)
        !running && !wr_start |=> !running && count == $past(count))
    else $error("idle counter moved");

    chk_expiry_stop:
    assert property (@(posedge clk) disable iff (!rst_b)
        hit_zero |=> !running && count == 8'h00)
    else $error("counter did not stop at zero");

    // Timer pending flag: set only by expiry, held until a write of one,
    // and set again by a later expiry without any write of zero.

    chk_tmr_no_spur:
    assert property (@(posedge clk) disable iff (!rst_b)
        !tmr_flag && !hit_zero |=> !tmr_flag)
    else $error("pending flag set without expiry");

    chk_tmr_hold:
    assert property (@(posedge clk) disable iff (!rst_b)
        tmr_flag && !(wr_irq && reg_wdata[0]) |=> tmr_flag)
    else $error("pending flag lost without write one");

    chk_tmr_rearm:
    assert property (@(posedge clk) disable iff (!rst_b)
        !tmr_flag && hit_zero |=> tmr_flag)
    else $error("pending flag not rearmed after clear");

    // Carrier flag: only the detector event may raise it

    chk_cd_no_spur:
    assert property (@(posedge clk) disable iff (!rst_b)
        !cd_flag && !carrier_detect |=> !cd_flag)
    else $error("carrier flag set without event");

    // Enable bits follow every write to the status register

    chk_cd_en_store:
    assert property (@(posedge clk) disable iff (!rst_b)
        wr_irq |=> cd_en == $past(reg_wdata[`IRT_BIT_CD_EN]))
    else $error("carrier enable not stored");

    chk_tmr_en_store:
    assert property (@(posedge clk) disable iff (!rst_b)
        wr_irq |=> tmr_en == $past(reg_wdata[`IRT_BIT_TMR_EN]))
    else $error("timer enable not stored");

    // Read data: what a read returns, and that it holds between reads.
    // Software may sample the byte late, so holding matters.

    chk_rdata_hold:
    assert property (@(posedge clk) disable iff (!rst_b)
        !rd_hit |=> $stable(reg_rdata))
    else $error("read data changed without a read");

    chk_rdata_status:
    assert property (@(posedge clk) disable iff (!rst_b)
        rd_hit && reg_addr == `IRT_OFS_IRQ |=>
        reg_rdata == {$past(cd_en), $past(cd_flag), 4'h0,
        $past(tmr_en), $past(tmr_flag)})
    else $error("status read returned wrong bits");

    chk_rdata_start:
    assert property (@(posedge clk) disable iff (!rst_b)
        rd_hit && reg_addr == `IRT_OFS_START |=>
        reg_rdata == $past(start_value))
    else $error("start value read returned wrong byte");

    chk_rdata_other:
    assert property (@(posedge clk) disable iff (!rst_b)
        rd_hit && reg_addr != `IRT_OFS_START
        && reg_addr != `IRT_OFS_IRQ |=> reg_rdata == 8'h00)
    else $error("unused offset read not zero");

    // Note: the block assumes the carrier detector and the register
    // strobes are already synchronous to clk; an asynchronous source
    // needs a synchroniser in front of this block.

endmodule // irt_timer
`default_nettype wire

// ==== verif/irt_host.sv ====
// Host model making register cycles and carrier events
`timescale 1ns/1ps
`default_nettype none
module irt_host (
    // Clock
    input wire logic clk,
    // Register port
    output var logic [2:0] reg_addr,
    output var logic [1:0] reg_bank,
    output var logic reg_wr,
    output var logic reg_rd,
    output var logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Carrier event
    output var logic carrier_detect
);
    // Idle bus at time zero
    initial begin
        reg_addr = 3'h0;
        reg_bank = 2'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        carrier_detect = 1'b0;
    end
    // One write, strobe high for one edge; data then turns stale
    task automatic wr(input logic [2:0] a, input logic [1:0] b,
                      input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_bank <= b;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_wdata <= ~d;
    endtask
    // One read, data taken once the strobe edge has landed
    task automatic rd(input logic [2:0] a, input logic [1:0] b,
                      output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_bank <= b;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Single-cycle carrier event
    task automatic pulse_cd;
        @(posedge clk);
        carrier_detect <= 1'b1;
        @(posedge clk);
        carrier_detect <= 1'b0;
    endtask
endmodule // irt_host
`default_nettype wire

// ==== verif/irt_timer_tb.sv ====
// Testbench of the IR interval timer and interrupt flags
`timescale 1ns/1ps
`default_nettype none
module irt_timer_tb;
    localparam int TICK = 4;
    logic clk, rst_b, reg_wr, reg_rd, carrier_detect, irq;
    logic [2:0] reg_addr;
    logic [1:0] reg_bank;
    logic [7:0] reg_wdata, reg_rdata, v;
    int error_cnt = 0;
    int num_checks = 0;
    int n;
    irt_timer #(.TICK_CYCLES(TICK)) dut (.clk(clk), .rst_b(rst_b),
        .reg_addr(reg_addr), .reg_bank(reg_bank), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .carrier_detect(carrier_detect), .irq(irq));
    irt_host host (.clk(clk), .reg_addr(reg_addr), .reg_bank(reg_bank),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .carrier_detect(carrier_detect));
    // Free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Compare one byte
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    // Verdict and end of run
    task automatic test_done;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Reset values, decode, readback
    task automatic t_decode;
        host.rd(3'h4, 2'h2, v);
        chk(v, 8'h00);
        host.wr(3'h4, 2'h1, 8'h5A);
        host.wr(3'h6, 2'h2, 8'hFF);
        host.rd(3'h4, 2'h2, v);
        chk(v, 8'h00);
        host.rd(3'h6, 2'h2, v);
        chk(v, 8'h00);
        host.wr(3'h4, 2'h2, 8'hA5);
        host.rd(3'h4, 2'h2, v);
        chk(v, 8'hA5);
        host.wr(3'h4, 2'h2, 8'h00);
        $display("t_decode done");
    endtask
    // Expiry time, pending flag, clear, mask
    task automatic t_timer;
        host.wr(3'h5, 2'h2, 8'h02);
        host.wr(3'h4, 2'h2, 8'h03);
        for (n = 0; n < 100 && irq !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        if (irq !== 1'b1) begin
            error_cnt++;
            $display("[FAIL] %0t timer expiry timed out", $time);
            test_done();
        end
        chk({7'h0, n >= 3 * TICK && n <= 3 * TICK + 2}, 8'h01);
        host.rd(3'h5, 2'h2, v);
        chk(v, 8'h03);
        host.wr(3'h5, 2'h2, 8'h03);
        host.rd(3'h5, 2'h2, v);
        chk(v, 8'h02);
        chk({7'h0, irq}, 8'h00);
        host.wr(3'h5, 2'h2, 8'h00);
        host.wr(3'h4, 2'h2, 8'h01);
        repeat (TICK + 3) @(posedge clk);
        #1 chk({7'h0, irq}, 8'h00);
        host.rd(3'h5, 2'h2, v);
        chk(v, 8'h01);
        $display("t_timer done");
    endtask
    // Carrier flag, mask, write-one clear
    task automatic t_carrier;
        host.wr(3'h5, 2'h2, 8'h01);
        host.pulse_cd();
        repeat (2) @(posedge clk);
        #1 chk({7'h0, irq}, 8'h00);
        host.rd(3'h5, 2'h2, v);
        chk(v, 8'h40);
        host.wr(3'h5, 2'h2, 8'h80);
        repeat (2) @(posedge clk);
        #1 chk({7'h0, irq}, 8'h01);
        host.rd(3'h5, 2'h2, v);
        chk(v, 8'hC0);
        host.wr(3'h5, 2'h2, 8'hC0);
        host.rd(3'h5, 2'h2, v);
        chk(v, 8'h80);
        chk({7'h0, irq}, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk(reg_rdata, 8'h80);
        $display("t_carrier done");
    endtask
    // Main sequence
    initial begin
        rst_b = 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        t_decode();
        t_timer();
        t_carrier();
        test_done();
    end
endmodule // irt_timer_tb
`default_nettype wire
